// file: hw/dtbs_consts.vh
`ifndef DTBS_CONSTS_VH
`define DTBS_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets (wishbone, 32-bit words)
// ---------------------------------------------------------------
`define DTBS_OFS_CTRL      8'h00
`define DTBS_OFS_STATUS    8'h04
`define DTBS_OFS_SLOT_SEL  8'h08
`define DTBS_OFS_ON_TIME   8'h0c
`define DTBS_OFS_OFF_TIME  8'h10
`define DTBS_OFS_COPY      8'h14
`define DTBS_OFS_SEQ_ADDR  8'h18
`define DTBS_OFS_SEQ_DATA  8'h1c
`define DTBS_OFS_SEQ_END   8'h20
`define DTBS_OFS_BIT_PER   8'h24
`define DTBS_OFS_ON_LEV    8'h28
`define DTBS_OFS_OFF_LEV   8'h2c
`define DTBS_OFS_AMPL      8'h30
`define DTBS_OFS_CMD       8'h34
`define DTBS_OFS_DIAL      8'h38
// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define DTBS_CTRL_MODE     0
`define DTBS_CTRL_BASE_LO  1
`define DTBS_CTRL_BASE_HI  2
// ---------------------------------------------------------------
// command codes (cmd register, bits 1:0)
// ---------------------------------------------------------------
`define DTBS_CMD_STOP      2'h0
`define DTBS_CMD_STEP      2'h1
`define DTBS_CMD_SINGLE    2'h2
`define DTBS_CMD_CONT      2'h3
// ---------------------------------------------------------------
// timing: time fields in 10 us units
// ---------------------------------------------------------------
`define DTBS_CLK_HZ        50000000
`define DTBS_TICK_US       10
`define DTBS_TICK_CYC      ((`DTBS_CLK_HZ / 1000000) * `DTBS_TICK_US)
`define DTBS_TIME_DEF      16'h0064
`define DTBS_TIME_MIN_TONE 16'h0064
`define DTBS_TIME_MIN_BIT  16'h000a
`define DTBS_NUM_SLOTS     16
`define DTBS_TONE_LEN_MAX  250
`define DTBS_BIT_LEN_MAX   1000
`define DTBS_AMPL_RESET    16'h0000
`endif

// file: hw/dtbs_slot_times.v
`timescale 1ns/1ns
`include "dtbs_consts.vh"
// per-slot on and off times with broadcast copy
module dtbs_slot_times #(
    parameter SLOTS = `DTBS_NUM_SLOTS
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // write port
    input  wire [3:0]  wr_slot,
    input  wire        wr_on,
    input  wire        wr_off,
    input  wire [15:0] wr_val,
    input  wire        copy_on,
    input  wire        copy_off,
    // read ports
    input  wire [3:0]  rd_slot,
    output wire [15:0] rd_on,
    output wire [15:0] rd_off,
    input  wire [3:0]  pl_slot,
    output wire [15:0] pl_on,
    output wire [15:0] pl_off
);
    reg [15:0] on_q  [0:SLOTS-1];
    reg [15:0] off_q [0:SLOTS-1];
    genvar i;
    generate
        for (i = 0; i < SLOTS; i = i + 1) begin : g_slot
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    on_q[i]  <= `DTBS_TIME_DEF;
                    off_q[i] <= `DTBS_TIME_DEF;
                end else begin
                    if (wr_on && wr_slot == i)
                        on_q[i] <= wr_val;
                    else if (copy_on)
                        on_q[i] <= on_q[rd_slot];
                    if (wr_off && wr_slot == i)
                        off_q[i] <= wr_val;
                    else if (copy_off)
                        off_q[i] <= off_q[rd_slot];
                end
            end
        end
    endgenerate
    assign rd_on  = on_q[rd_slot];
    assign rd_off = off_q[rd_slot];
    assign pl_on  = on_q[pl_slot];
    assign pl_off = off_q[pl_slot];
endmodule // dtbs_slot_times

// file: hw/dtbs_tick.v
`timescale 1ns/1ns
`include "dtbs_consts.vh"
// 10 us tick divider
module dtbs_tick #(
    parameter TICK_CYC = `DTBS_TICK_CYC
) (
    // clock and reset
    input  wire ref_clk,
    input  wire reset_n,
    // tick
    output reg  tick
);
    reg [15:0] cnt_q;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b0;
        end else if (cnt_q == TICK_CYC[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // dtbs_tick

// file: hw/dtbs_top.v
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "dtbs_consts.vh"
module dtbs_top #(
    parameter TICK_CYC = `DTBS_TICK_CYC
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // synthesizer output
    output reg         tone_en,
    output reg  [3:0]  tone_slot,
    output reg         bit_en,
    output reg  [15:0] out_level,
    output reg  [15:0] out_ampl
);
    // -----------------------------------------------------------
    // states
    // -----------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_ON   = 2'd1;
    localparam ST_OFF  = 2'd2;
    localparam RUN_STEP = 2'd1;
    localparam RUN_SGL  = 2'd2;
    localparam RUN_CONT = 2'd3;

    // -----------------------------------------------------------
    // registers
    // -----------------------------------------------------------
    reg        mode_q;
    reg [1:0]  base_q;
    reg [3:0]  sel_q;
    reg [9:0]  seq_addr_q;
    reg [9:0]  seq_end_q;
    reg [15:0] bit_per_q;
    reg [15:0] on_lev_q;
    reg [15:0] off_lev_q;
    reg [15:0] ampl_q;
    reg        ampl_set_q;
    reg [1:0]  run_q;
    reg [1:0]  st_q;
    reg [9:0]  pos_q;
    reg [15:0] tcnt_q;
    reg        dial_q;
    reg [3:0]  dial_slot_q;
    reg [3:0]  tone_mem [0:`DTBS_TONE_LEN_MAX-1];
    reg        bit_mem  [0:`DTBS_BIT_LEN_MAX-1];

    wire       tick;
    wire [15:0] rd_on;
    wire [15:0] rd_off;
    wire [15:0] pl_on;
    wire [15:0] pl_off;
    wire [3:0] cur_slot;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
    wire wr_on  = wb_wr && wb_adr_i == `DTBS_OFS_ON_TIME;
    wire wr_off = wb_wr && wb_adr_i == `DTBS_OFS_OFF_TIME;
    wire cp_on  = wb_wr && wb_adr_i == `DTBS_OFS_COPY && wb_dat_i[0];
    wire cp_off = wb_wr && wb_adr_i == `DTBS_OFS_COPY && wb_dat_i[1];
    wire wr_cmd = wb_wr && wb_adr_i == `DTBS_OFS_CMD;
    wire wr_dial = wb_wr && wb_adr_i == `DTBS_OFS_DIAL;
    wire [15:0] wr_time = (wb_dat_i[15:0] < `DTBS_TIME_MIN_TONE) ?
                          `DTBS_TIME_MIN_TONE : wb_dat_i[15:0];

    // -----------------------------------------------------------
    // submodules
    // -----------------------------------------------------------
    dtbs_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    dtbs_slot_times u_times (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .wr_slot  (sel_q),
        .wr_on    (wr_on),
        .wr_off   (wr_off),
        .wr_val   (wr_time),
        .copy_on  (cp_on),
        .copy_off (cp_off),
        .rd_slot  (sel_q),
        .rd_on    (rd_on),
        .rd_off   (rd_off),
        .pl_slot  (cur_slot),
        .pl_on    (pl_on),
        .pl_off   (pl_off)
    );

    // slot index equals key code 0-9,a-d,e=star,f=pound
    assign cur_slot = dial_q ? dial_slot_q : tone_mem[pos_q[7:0]];

    // -----------------------------------------------------------
    // string memories, written by index
    // -----------------------------------------------------------
    always @(posedge ref_clk) begin
        if (wb_wr && wb_adr_i == `DTBS_OFS_SEQ_DATA) begin
            // stored raw; base is display formatting only
            if (mode_q)
                bit_mem[seq_addr_q] <= wb_dat_i[0];
            else if (seq_addr_q < `DTBS_TONE_LEN_MAX)
                tone_mem[seq_addr_q[7:0]] <= wb_dat_i[3:0];
        end
    end

    // -----------------------------------------------------------
    // wishbone register file
    // -----------------------------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
            mode_q     <= 1'b0;
            base_q     <= 2'h0;
            sel_q      <= 4'h0;
            seq_addr_q <= 10'h000;
            seq_end_q  <= 10'h000;
            bit_per_q  <= `DTBS_TIME_MIN_BIT;
            on_lev_q   <= 16'h0000;
            off_lev_q  <= 16'h0000;
            ampl_q     <= `DTBS_AMPL_RESET;
            ampl_set_q <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_wr) begin
                if (wb_adr_i == `DTBS_OFS_CTRL) begin
                    mode_q <= wb_dat_i[`DTBS_CTRL_MODE];
                    base_q <= wb_dat_i[`DTBS_CTRL_BASE_HI:`DTBS_CTRL_BASE_LO];
                end else if (wb_adr_i == `DTBS_OFS_SLOT_SEL)
                    sel_q <= wb_dat_i[3:0];
                else if (wb_adr_i == `DTBS_OFS_SEQ_ADDR) begin
                    if (wb_dat_i[9:0] < `DTBS_BIT_LEN_MAX)
                        seq_addr_q <= wb_dat_i[9:0];
                end else if (wb_adr_i == `DTBS_OFS_SEQ_DATA) begin
                    if (seq_addr_q < `DTBS_BIT_LEN_MAX - 1)
                        seq_addr_q <= seq_addr_q + 10'h001;
                end else if (wb_adr_i == `DTBS_OFS_SEQ_END) begin
                    if (mode_q && wb_dat_i[9:0] < `DTBS_BIT_LEN_MAX)
                        seq_end_q <= wb_dat_i[9:0];
                    else if (!mode_q &&
                             wb_dat_i[9:0] < `DTBS_TONE_LEN_MAX)
                        seq_end_q <= wb_dat_i[9:0];
                end else if (wb_adr_i == `DTBS_OFS_BIT_PER)
                    bit_per_q <= (wb_dat_i[15:0] < `DTBS_TIME_MIN_BIT) ?
                                 `DTBS_TIME_MIN_BIT : wb_dat_i[15:0];
                else if (wb_adr_i == `DTBS_OFS_ON_LEV)
                    on_lev_q <= wb_dat_i[15:0];
                else if (wb_adr_i == `DTBS_OFS_OFF_LEV)
                    off_lev_q <= wb_dat_i[15:0];
                else if (wb_adr_i == `DTBS_OFS_AMPL) begin
                    ampl_q     <= wb_dat_i[15:0];
                    ampl_set_q <= 1'b1;
                end
            end else if (wb_req) begin
                if (wb_adr_i == `DTBS_OFS_CTRL)
                    wb_dat_o <= {29'h0, base_q, mode_q};
                else if (wb_adr_i == `DTBS_OFS_STATUS)
                    wb_dat_o <= {12'h0, 2'h0, st_q, 6'h0, pos_q};
                else if (wb_adr_i == `DTBS_OFS_SLOT_SEL)
                    wb_dat_o <= {28'h0, sel_q};
                else if (wb_adr_i == `DTBS_OFS_ON_TIME)
                    wb_dat_o <= {16'h0, rd_on};
                else if (wb_adr_i == `DTBS_OFS_OFF_TIME)
                    wb_dat_o <= {16'h0, rd_off};
                else if (wb_adr_i == `DTBS_OFS_SEQ_ADDR)
                    wb_dat_o <= {22'h0, seq_addr_q};
                else if (wb_adr_i == `DTBS_OFS_SEQ_DATA)
                    wb_dat_o <= mode_q ? {31'h0, bit_mem[seq_addr_q]} :
                                {28'h0, tone_mem[seq_addr_q[7:0]]};
                else if (wb_adr_i == `DTBS_OFS_SEQ_END)
                    wb_dat_o <= {22'h0, seq_end_q};
                else if (wb_adr_i == `DTBS_OFS_BIT_PER)
                    wb_dat_o <= {16'h0, bit_per_q};
                else if (wb_adr_i == `DTBS_OFS_ON_LEV)
                    wb_dat_o <= {16'h0, on_lev_q};
                else if (wb_adr_i == `DTBS_OFS_OFF_LEV)
                    wb_dat_o <= {16'h0, off_lev_q};
                else if (wb_adr_i == `DTBS_OFS_AMPL)
                    wb_dat_o <= {16'h0, ampl_q};
                else if (wb_adr_i == `DTBS_OFS_CMD)
                    wb_dat_o <= {30'h0, run_q};
            end
        end
    end

    // -----------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------
    wire at_end = (pos_q == seq_end_q);
    wire [15:0] per_on = mode_q ? bit_per_q : pl_on;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q       <= `DTBS_CMD_STOP;
            st_q        <= ST_IDLE;
            pos_q       <= 10'h000;
            tcnt_q      <= 16'h0000;
            dial_q      <= 1'b0;
            dial_slot_q <= 4'h0;
        end else if (wr_cmd && wb_dat_i[1:0] == `DTBS_CMD_STOP) begin
            run_q  <= `DTBS_CMD_STOP;
            st_q   <= ST_IDLE;
            dial_q <= 1'b0;
        end else if (wr_cmd) begin
            run_q  <= wb_dat_i[1:0];
            dial_q <= 1'b0;
            tcnt_q <= 16'h0000;
            st_q   <= ST_ON;
            if (wb_dat_i[1:0] == `DTBS_CMD_STEP && st_q != ST_IDLE)
                pos_q <= at_end ? 10'h000 : pos_q + 10'h001;
            else if (wb_dat_i[1:0] != `DTBS_CMD_STEP)
                pos_q <= 10'h000;
        end else if (wr_dial && !mode_q) begin
            dial_q      <= 1'b1;
            dial_slot_q <= wb_dat_i[3:0];
            run_q       <= `DTBS_CMD_STOP;
            st_q        <= ST_ON;
            tcnt_q      <= 16'h0000;
        end else if (tick) begin
            case (st_q)
                ST_ON: begin
                    if (tcnt_q + 16'h0001 >= per_on) begin
                        tcnt_q <= 16'h0000;
                        if (dial_q) begin
                            st_q   <= ST_IDLE;
                            dial_q <= 1'b0;
                        end else if (mode_q) begin
                            if (run_q == RUN_STEP)
                                st_q <= ST_IDLE;
                            else if (!at_end)
                                pos_q <= pos_q + 10'h001;
                            else if (run_q == RUN_CONT)
                                pos_q <= 10'h000;
                            else
                                st_q <= ST_IDLE;
                        end else
                            st_q <= ST_OFF;
                    end else
                        tcnt_q <= tcnt_q + 16'h0001;
                end
                ST_OFF: begin
                    if (tcnt_q + 16'h0001 >= pl_off) begin
                        tcnt_q <= 16'h0000;
                        if (run_q == RUN_STEP)
                            st_q <= ST_IDLE;
                        else if (!at_end) begin
                            pos_q <= pos_q + 10'h001;
                            st_q  <= ST_ON;
                        end else if (run_q == RUN_CONT) begin
                            pos_q <= 10'h000;
                            st_q  <= ST_ON;
                        end else
                            st_q <= ST_IDLE;
                    end else
                        tcnt_q <= tcnt_q + 16'h0001;
                end
                default: tcnt_q <= 16'h0000;
            endcase
        end
    end

    // -----------------------------------------------------------
    // output registers
    // -----------------------------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tone_en   <= 1'b0;
            tone_slot <= 4'h0;
            bit_en    <= 1'b0;
            out_level <= 16'h0000;
            out_ampl  <= 16'h0000;
        end else begin
            tone_en   <= !mode_q && st_q == ST_ON && ampl_set_q;
            if (!mode_q && st_q == ST_ON)
                tone_slot <= cur_slot;
            bit_en    <= mode_q && ampl_set_q;
            out_ampl  <= ampl_set_q ? ampl_q : 16'h0000;
            if (mode_q && st_q == ST_ON && bit_mem[pos_q])
                out_level <= on_lev_q;
            else if (mode_q)
                out_level <= off_lev_q;
            else
                out_level <= 16'h0000;
        end
    end
endmodule // dtbs_top

// file: verif/dtbs_tone_sink.sv
`timescale 1ns/1ns
// records what the analog path would sound
module dtbs_tone_sink (
    // clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // synthesizer inputs
    input wire        tone_en,
    input wire [3:0]  tone_slot,
    input wire        bit_en,
    input wire [15:0] out_level,
    input wire [15:0] out_ampl
);
    logic [3:0] slots[$];
    int         on_len  = 0;
    int         last_on = 0;
    logic       prev_q  = 1'b0;
    always @(posedge ref_clk) begin
        prev_q <= tone_en;
        if (tone_en === 1'b1 && !prev_q)
            slots.push_back(tone_slot);
        if (tone_en === 1'b1)
            on_len <= on_len + 1;
        else if (prev_q) begin
            last_on <= on_len;
            on_len  <= 0;
        end
    end
endmodule // dtbs_tone_sink

// file: verif/dtbs_top_props.sv
`timescale 1ns/1ns
module dtbs_top_props #(
    parameter TICK_CYC = 500
) (
    // clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // synthesizer output
    input wire        tone_en,
    input wire [3:0]  tone_slot,
    input wire        bit_en,
    input wire [15:0] out_level,
    input wire [15:0] out_ampl
);
    localparam int ON_MAX = 65535 * TICK_CYC + TICK_CYC;
    reg  [31:0] on_cnt_q;
    wire        ampl_wr;
    assign ampl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == 8'h30);
    // length of the current on phase
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            on_cnt_q <= 32'h0;
        else
            on_cnt_q <= tone_en ? on_cnt_q + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    silent_no_ampl_a: assert property (
        out_ampl == 16'h0 |-> !tone_en && !bit_en)
        else $error("output active before amplitude set");
    tone_level_a: assert property (
        tone_en |-> out_level == 16'h0 && !bit_en)
        else $error("bit level present during tone");
    slot_hold_a: assert property (
        tone_en && $past(tone_en) |-> $stable(tone_slot))
        else $error("slot changed during on phase");
    ampl_from_write_a: assert property (
        $changed(out_ampl) |-> $past(ampl_wr) || $past(ampl_wr, 2))
        else $error("amplitude changed without write");
    on_time_max_a: assert property (on_cnt_q <= ON_MAX)
        else $error("on phase longer than maximum");
endmodule // dtbs_top_props

bind dtbs_top dtbs_top_props #(.TICK_CYC(TICK_CYC)) u_dtbs_top_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tone_en(tone_en), .tone_slot(tone_slot),
    .bit_en(bit_en), .out_level(out_level), .out_ampl(out_ampl));

// file: verif/dtbs_top_test.sv
`timescale 1ns/1ns
`include "dtbs_consts.vh"
module dtbs_top_test;
    localparam int TICK = 5;
    localparam int ON_C = 150 * TICK;
    reg         ref_clk  = 1'b0;
    reg         reset_n  = 1'b0;
    reg         wb_cyc_i = 1'b0;
    reg         wb_stb_i = 1'b0;
    reg         wb_we_i  = 1'b0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [3:0]  wb_sel_i = 4'hf;
    reg  [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire        tone_en;
    wire [3:0]  tone_slot;
    wire        bit_en;
    wire [15:0] out_level;
    wire [15:0] out_ampl;
    int         n_errors  = 0;
    int         tests_run = 0;
    int         cyc_n     = 0;
    logic [31:0] rd;
    logic [3:0]  seq [3] = '{4'h5, 4'he, 4'hf};

    always #10 ref_clk = ~ref_clk;

    dtbs_top #(.TICK_CYC(TICK)) u_dtbs_top (.ref_clk(ref_clk),
        .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tone_en(tone_en), .tone_slot(tone_slot), .bit_en(bit_en),
        .out_level(out_level), .out_ampl(out_ampl));
    dtbs_tone_sink u_dtbs_tone_sink (.ref_clk(ref_clk), .reset_n(reset_n),
        .tone_en(tone_en), .tone_slot(tone_slot), .bit_en(bit_en),
        .out_level(out_level), .out_ampl(out_ampl));

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input [7:0] a, input w, input [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
            n_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd_chk(input [7:0] a, input [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_starts(input int n);
        int k;
        k = 0;
        while (u_dtbs_tone_sink.slots.size() < n && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        check(u_dtbs_tone_sink.slots.size() >= n, 1);
    endtask
    task automatic wait_low();
        int k;
        k = 0;
        while (tone_en !== 1'b0 && k < 5000) begin
            @(posedge ref_clk);
            k++;
        end
        @(posedge ref_clk);
    endtask
    function automatic bit near(input int v, input int e);
        return (v >= e - TICK) && (v <= e + TICK);
    endfunction

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        foreach (seq[i]) begin
            wr(`DTBS_OFS_SLOT_SEL, {28'h0, seq[i]});
            rd_chk(`DTBS_OFS_ON_TIME, 32'h64);
            rd_chk(`DTBS_OFS_OFF_TIME, 32'h64);
        end
        rd_chk(8'h3c, 32'h0);
        check(out_ampl, 32'h0);
        $display("done: regs");
    endtask
    task automatic t_copy();
        wr(`DTBS_OFS_SLOT_SEL, 32'h3);
        wr(`DTBS_OFS_ON_TIME, 32'h96);
        wr(`DTBS_OFS_COPY, 32'h1);
        wr(`DTBS_OFS_OFF_TIME, 32'h80);
        wr(`DTBS_OFS_COPY, 32'h2);
        wr(`DTBS_OFS_SLOT_SEL, 32'h9);
        rd_chk(`DTBS_OFS_ON_TIME, 32'h96);
        rd_chk(`DTBS_OFS_OFF_TIME, 32'h80);
        wr(`DTBS_OFS_OFF_TIME, 32'h10);
        rd_chk(`DTBS_OFS_OFF_TIME, 32'h64);
        $display("done: copy");
    endtask
    task automatic t_step();
        wr(`DTBS_OFS_SEQ_ADDR, 32'h0);
        foreach (seq[i]) wr(`DTBS_OFS_SEQ_DATA, {28'h0, seq[i]});
        wr(`DTBS_OFS_SEQ_END, 32'h2);
        wr(`DTBS_OFS_AMPL, 32'h1234);
        repeat (3) @(posedge ref_clk);
        check(out_ampl, 32'h1234);
        wr(`DTBS_OFS_CMD, `DTBS_CMD_STEP);
        wait_starts(1);
        wait_low();
        wr(`DTBS_OFS_CMD, `DTBS_CMD_STEP);
        wait_starts(2);
        check(u_dtbs_tone_sink.slots[0], seq[0]);
        check(u_dtbs_tone_sink.slots[1], seq[1]);
        wait_low();
        wr(`DTBS_OFS_CMD, `DTBS_CMD_STOP);
        $display("done: step");
    endtask
    task automatic t_single();
        u_dtbs_tone_sink.slots.delete();
        wr(`DTBS_OFS_CMD, `DTBS_CMD_SINGLE);
        wait_starts(3);
        foreach (seq[i]) check(u_dtbs_tone_sink.slots[i], seq[i]);
        check(tone_slot, 32'hf);
        wait_low();
        check(near(u_dtbs_tone_sink.last_on, ON_C), 1);
        repeat (2000) @(posedge ref_clk);
        check(u_dtbs_tone_sink.slots.size(), 3);
        $display("done: single");
    endtask
    task automatic t_cont();
        int n;
        u_dtbs_tone_sink.slots.delete();
        wr(`DTBS_OFS_CMD, `DTBS_CMD_CONT);
        wait_starts(5);
        check(u_dtbs_tone_sink.slots[3], seq[0]);
        check(u_dtbs_tone_sink.slots[4], seq[1]);
        wr(`DTBS_OFS_CMD, `DTBS_CMD_STOP);
        repeat (3) @(posedge ref_clk);
        check(tone_en, 1'b0);
        n = u_dtbs_tone_sink.slots.size();
        repeat (1500) @(posedge ref_clk);
        check(u_dtbs_tone_sink.slots.size(), n);
        $display("done: continuous");
    endtask
    task automatic t_dial();
        u_dtbs_tone_sink.slots.delete();
        wr(`DTBS_OFS_DIAL, 32'hc);
        wait_starts(1);
        check(u_dtbs_tone_sink.slots[0], 32'hc);
        wait_low();
        check(near(u_dtbs_tone_sink.last_on, ON_C), 1);
        $display("done: dial");
    endtask
    task automatic t_bits();
        int k;
        wr(`DTBS_OFS_ON_LEV, 32'haaaa);
        wr(`DTBS_OFS_OFF_LEV, 32'h5555);
        wr(`DTBS_OFS_BIT_PER, 32'h3);
        rd_chk(`DTBS_OFS_BIT_PER, 32'ha);
        // bit data only lands in the bit string in bit mode
        wr(`DTBS_OFS_CTRL, 32'h1);
        wr(`DTBS_OFS_SEQ_ADDR, 32'h0);
        wr(`DTBS_OFS_SEQ_DATA, 32'h1);
        wr(`DTBS_OFS_SEQ_DATA, 32'h0);
        wr(`DTBS_OFS_SEQ_DATA, 32'h1);
        for (int b = 0; b < 3; b += 2) begin
            wr(`DTBS_OFS_CTRL, 32'h1 | (b << 1));
            repeat (3) @(posedge ref_clk);
            check(out_level, 32'h5555);
            check(bit_en, 1'b1);
            wr(`DTBS_OFS_CMD, `DTBS_CMD_SINGLE);
            k = 0;
            while (out_level !== 16'haaaa && k < 200) begin
                @(posedge ref_clk);
                k++;
            end
            repeat (25) @(posedge ref_clk);
            check(out_level, 32'haaaa);
            repeat (50) @(posedge ref_clk);
            check(out_level, 32'h5555);
            repeat (50) @(posedge ref_clk);
            check(out_level, 32'haaaa);
            repeat (50) @(posedge ref_clk);
            check(out_level, 32'h5555);
        end
        wr(`DTBS_OFS_DIAL, 32'h2);
        repeat (10) @(posedge ref_clk);
        check(tone_en, 1'b0);
        $display("done: bits");
    endtask

    // ----------------------------------------------------------
    // run control
    // ----------------------------------------------------------
    task automatic close_out();
        $display("compared %0d, mismatched %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_copy();
        t_step();
        t_single();
        t_cont();
        t_dial();
        t_bits();
        close_out();
    end
endmodule // dtbs_top_test
